// File: design/sfsp_front_end.sv
`timescale 1ns/1ps

module sfsp_front_end
	import sfsp_pkg::*;
#(
	parameter int SECTORS = 16,
	parameter int PAGES = 256,
	parameter int PAGE_BYTES = 256
)
(
	input wire logic CLOCK, // system clock
	input wire logic RSTN, // async reset, active low
	input wire logic SPI_CLK, // serial clock from master
	input wire logic SPI_CS_N, // chip select, active low
	input wire logic SPI_SDI, // serial data in
	input wire logic SPI_HOLD_N, // hold, active low
	input wire logic SPI_WP_N, // write protect, active low
	output logic SPI_SDO, // serial data out
	output logic SPI_SDO_OE, // output enable for serial data out
	output logic BUSY, // internal cycle running
	output logic STANDBY // standby power state
);

	localparam int SEC_W = $clog2(SECTORS);
	localparam int PB_W = $clog2(PAGE_BYTES);
	localparam int ADDR_W = $clog2(SECTORS * PAGES * PAGE_BYTES);
	localparam int MEM_BYTES = SECTORS * PAGES * PAGE_BYTES;
	localparam int SEC_BYTES = PAGES * PAGE_BYTES;
	localparam int CNT_W = ADDR_W + 1;

	// protected top sectors for a guard size code
	function automatic logic sector_guarded(input logic [SEC_W-1:0] sec, input logic [2:0] g);
		int n;
		n = (g >= GUARD_ALL) ? SECTORS : ((g == GUARD_NONE) ? 0 : (1 << (int'(g) - 1)));
		return (int'(sec) >= SECTORS - n);
	endfunction

	logic [7:0] mem [MEM_BYTES];
	logic [7:0] pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_reg;

	logic [4:0] s1_reg, s2_reg, s3_reg;
	logic sel_reg, data_seen_reg, sdo_reg, oe_reg, standby_reg, wel_reg, lock_reg;
	logic [2:0] bit_cnt_reg, byte_idx_reg, guard_size_reg;
	logic [6:0] shift_reg;
	logic [7:0] opcode_reg, out_shift_reg, out_shift_next;
	logic [ADDR_BITS-1:0] addr_reg, addr_next;
	sfsp_state_t state_reg, state_next;
	logic [CNT_W-1:0] work_cnt_reg, work_last, len_reg;
	logic [ADDR_W-1:0] base_reg;

	// synchronised pins and edges
	wire sck_s = s2_reg[PIN_SCK];
	wire cs_n_s = s2_reg[PIN_CS];
	wire sdi_s = s2_reg[PIN_SDI];
	wire hold_n_s = s2_reg[PIN_HOLD];
	wire wp_n_s = s2_reg[PIN_WP];
	// edges found regardless of idle level
	wire sck_rise = sck_s & ~s3_reg[PIN_SCK];
	wire sck_fall = ~sck_s & s3_reg[PIN_SCK];
	wire cs_fall = ~cs_n_s & s3_reg[PIN_CS];
	wire cs_rise = cs_n_s & ~s3_reg[PIN_CS];
	// clock and input ignored under hold
	wire active = sel_reg & ~cs_n_s & hold_n_s;
	wire rx_edge = active & sck_rise;
	wire tx_edge = active & sck_fall;

	// byte assembly, most significant bit first
	// msb first assembly
	wire [7:0] byte_in = {shift_reg, sdi_s};
	wire byte_done = rx_edge & (bit_cnt_reg == BIT_LAST);
	wire idle = (state_reg == S_IDLE);
	wire [7:0] opcode_cur = (byte_idx_reg == IDX_OPCODE) ? byte_in : opcode_reg;
	wire at_addr = byte_done & (byte_idx_reg >= IDX_FIRST_ARG) & (byte_idx_reg <= IDX_LAST_ADDR);
	wire data_byte = byte_done & (byte_idx_reg == IDX_DATA);
	wire rd_cmd = idle & (opcode_reg == OP_DATA_READ);
	wire pg_cmd = idle & (opcode_reg == OP_PAGE_WRITE);
	wire [ADDR_BITS-1:0] a_shift = {addr_reg[ADDR_BITS-9:0], byte_in};
	wire [PB_W-1:0] pg_idx = addr_reg[PB_W-1:0];
	wire [ADDR_BITS-1:0] page_inc = {addr_reg[ADDR_BITS-1:PB_W], pg_idx + 1'b1};
	wire [ADDR_BITS-1:0] rd_addr = at_addr ? a_shift : addr_reg + 24'h1;
	wire [7:0] mem_rd = mem[rd_addr[ADDR_W-1:0]];
	wire st_load = byte_done & (opcode_cur == OP_STATUS_READ);
	wire rd_load = byte_done & rd_cmd & (byte_idx_reg >= IDX_LAST_ADDR);
	wire pg_store = data_byte & pg_cmd;
	wire mask_clr = byte_done & (byte_idx_reg == IDX_OPCODE) & idle;
	wire [7:0] status = {lock_reg, STATUS_ZERO, guard_size_reg, wel_reg, ~idle};

	// address path: shift in, read increment, page-wrapped write increment
	assign addr_next = at_addr ? a_shift :
		(data_byte & rd_cmd) ? addr_reg + 24'h1 :
		pg_store ? page_inc : addr_reg;

	// output shifter: load on byte end, shift on falling edge
	assign out_shift_next = st_load ? status :
		rd_load ? mem_rd :
		tx_edge ? {out_shift_reg[6:0], 1'b0} : out_shift_reg;

	// acceptance at deselect
	// whole bytes only
	wire whole = (bit_cnt_reg == BIT_FIRST);
	wire go = cs_rise & sel_reg & whole & idle;
	wire [SEC_W-1:0] addr_sec = addr_reg[ADDR_W-1 -: SEC_W];
	// guard bits locked by write protect
	wire locked = ~wp_n_s & lock_reg;
	wire acc_wen = go & (opcode_reg == OP_WRITE_ENABLE) & (byte_idx_reg == IDX_FIRST_ARG);
	wire acc_wdis = go & (opcode_reg == OP_WRITE_DISABLE) & (byte_idx_reg == IDX_FIRST_ARG);
	wire acc_wrst = go & wel_reg & (opcode_reg == OP_STATUS_WRITE) & (byte_idx_reg == IDX_STATUS_END);
	// page write needs at least one data byte
	wire acc_page = go & wel_reg & (opcode_reg == OP_PAGE_WRITE) & (byte_idx_reg == IDX_DATA) &
		data_seen_reg & ~sector_guarded(addr_sec, guard_size_reg);
	wire acc_region = go & wel_reg & (opcode_reg == OP_REGION_WIPE) & (byte_idx_reg == IDX_DATA) &
		~sector_guarded(addr_sec, guard_size_reg);
	wire acc_full = go & wel_reg & (opcode_reg == OP_FULL_WIPE) & (byte_idx_reg == IDX_FIRST_ARG) &
		(guard_size_reg == GUARD_NONE);

	// internal cycle sequencing
	wire done = ~idle & (work_cnt_reg == work_last);
	wire [ADDR_W-1:0] mem_wa = base_reg + work_cnt_reg[ADDR_W-1:0];
	wire [PB_W-1:0] work_idx = work_cnt_reg[PB_W-1:0];
	wire mem_we = ((state_reg == S_PROG) & mask_reg[work_idx]) | (state_reg == S_ERASE);
	wire [7:0] mem_wd = (state_reg == S_PROG) ? (mem[mem_wa] & pbuf[work_idx]) : ERASED_BYTE;

	// cycle length: fixed for program and status write, loaded for erase
	assign work_last = (state_reg == S_PROG) ? CNT_W'(PAGE_BYTES - 1) :
		(state_reg == S_STATUS) ? CNT_W'(STATUS_WRITE_CYC - 1) : len_reg - 1'b1;

	// next state
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE:
			begin
				if (acc_page)
					state_next = S_PROG;
				else if (acc_region | acc_full)
					state_next = S_ERASE;
				else if (acc_wrst)
					state_next = S_STATUS;
			end
			S_PROG, S_ERASE, S_STATUS:
				if (done)
					state_next = S_IDLE;
		endcase
	end

	// pin synchronisers, first stage read only by second
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			s1_reg <= SYNC_RST;
			s2_reg <= SYNC_RST;
			s3_reg <= SYNC_RST;
		end
		else
		begin
			s1_reg <= {SPI_WP_N, SPI_HOLD_N, SPI_SDI, SPI_CS_N, SPI_CLK};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// selection tracking
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
			sel_reg <= 1'b0;
		else if (cs_fall)
			sel_reg <= 1'b1;
		else if (cs_n_s)
			sel_reg <= 1'b0;
	end

	// bit and byte counting; state held while hold is active
	// counters frozen under hold
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			bit_cnt_reg <= BIT_FIRST;
			shift_reg <= 7'h00;
			byte_idx_reg <= IDX_OPCODE;
			opcode_reg <= OP_NONE;
			data_seen_reg <= 1'b0;
		end
		else if (cs_fall)
		begin
			bit_cnt_reg <= BIT_FIRST;
			byte_idx_reg <= IDX_OPCODE;
			opcode_reg <= OP_NONE;
			data_seen_reg <= 1'b0;
		end
		else if (rx_edge)
		begin
			bit_cnt_reg <= bit_cnt_reg + 1'b1;
			shift_reg <= byte_in[6:0];
			if (byte_done && byte_idx_reg == IDX_OPCODE)
				opcode_reg <= byte_in;
			if (byte_done && byte_idx_reg != IDX_DATA)
				byte_idx_reg <= byte_idx_reg + 1'b1;
			if (pg_store)
				data_seen_reg <= 1'b1;
		end
	end

	// address, output data path, drive enable and power state
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			addr_reg <= 24'h000000;
			out_shift_reg <= 8'h00;
			sdo_reg <= 1'b0;
			oe_reg <= 1'b0;
			standby_reg <= 1'b1;
		end
		else
		begin
			addr_reg <= addr_next;
			out_shift_reg <= out_shift_next;
			if (tx_edge)
				sdo_reg <= out_shift_reg[7];
			oe_reg <= active;
			standby_reg <= ~sel_reg & (state_next == S_IDLE); // next state: no blink at cycle start
		end
	end

	// internal cycle state, work counter, write enable latch and status bits
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_reg <= S_IDLE;
			work_cnt_reg <= '0;
			len_reg <= '0;
			base_reg <= '0;
			wel_reg <= 1'b0;
			lock_reg <= 1'b0;
			guard_size_reg <= GUARD_RST;
		end
		else
		begin
			state_reg <= state_next;
			work_cnt_reg <= (idle || done) ? '0 : work_cnt_reg + 1'b1;
			if (acc_page)
				base_reg <= {addr_reg[ADDR_W-1:PB_W], {PB_W{1'b0}}};
			if (acc_region)
			begin
				base_reg <= {addr_sec, {(ADDR_W - SEC_W){1'b0}}};
				len_reg <= CNT_W'(SEC_BYTES);
			end
			if (acc_full)
			begin
				base_reg <= '0;
				len_reg <= CNT_W'(MEM_BYTES);
			end
			if (acc_wen)
				wel_reg <= 1'b1;
			else if (acc_wdis || done)
				wel_reg <= 1'b0;
			if (acc_wrst && !locked)
			begin
				guard_size_reg <= addr_reg[SB_GUARD_HI:SB_GUARD_LO];
				lock_reg <= addr_reg[SB_LOCK];
			end
		end
	end

	// page buffer collect mask
	// up to one page of bytes
	always_ff @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
			mask_reg <= '0;
		else if (mask_clr)
			mask_reg <= '0;
		else if (pg_store)
			mask_reg[pg_idx] <= 1'b1;
	end

	// page buffer fill and array write: program clears bits, erase sets bytes
	always_ff @(posedge CLOCK)
	begin
		if (pg_store)
			pbuf[pg_idx] <= byte_in;
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign SPI_SDO = sdo_reg;
	assign SPI_SDO_OE = oe_reg;
	assign BUSY = ~idle;
	assign STANDBY = standby_reg;

endmodule

// File: inc/sfsp_pkg.sv
package sfsp_pkg;

	// system clock period and internal status-write time
	localparam int CLK_PERIOD_NS = 100;
	localparam int STATUS_WRITE_NS = 10000;
	localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// command codes
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_DATA_READ = 8'h03;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_REGION_WIPE = 8'hd8;
	localparam logic [7:0] OP_FULL_WIPE = 8'hc7;

	// byte positions within a command frame
	localparam logic [2:0] IDX_OPCODE = 3'h0;
	localparam logic [2:0] IDX_FIRST_ARG = 3'h1;
	localparam logic [2:0] IDX_STATUS_END = 3'h2;
	localparam logic [2:0] IDX_LAST_ADDR = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam int ADDR_BITS = 24;

	// status byte layout
	localparam int SB_BUSY = 0;
	localparam int SB_WEL = 1;
	localparam int SB_GUARD_LO = 2;
	localparam int SB_GUARD_HI = 4;
	localparam int SB_LOCK = 7;
	localparam logic [2:0] GUARD_RST = 3'h0;
	localparam logic [2:0] GUARD_NONE = 3'h0;
	localparam logic [2:0] GUARD_ALL = 3'h5;
	localparam logic [1:0] STATUS_ZERO = 2'h0;

	// value of an erased byte
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// synchroniser reset: {wp_n, hold_n, sdi, cs_n, sck}
	localparam logic [4:0] SYNC_RST = 5'h18;
	localparam int PIN_SCK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_HOLD = 3;
	localparam int PIN_WP = 4;

	// internal cycle states, gray along idle->prog/status->idle; erase (11) differs from idle in both bits
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_PROG = 2'b01,
		S_ERASE = 2'b11,
		S_STATUS = 2'b10
	} sfsp_state_t;

endpackage

// File: sim/sfsp_checker.sv
`timescale 1ns/1ps

// pin-level watcher for the flash front end
module sfsp_checker
(
	input wire logic CLOCK, // system clock
	input wire logic RSTN, // reset, active low
	input wire logic SPI_CLK, // serial clock
	input wire logic SPI_CS_N, // chip select
	input wire logic SPI_SDI, // serial data in
	input wire logic SPI_HOLD_N, // hold
	input wire logic SPI_WP_N, // write protect
	input wire logic SPI_SDO, // serial data out
	input wire logic SPI_SDO_OE, // output enable
	input wire logic BUSY, // internal cycle
	input wire logic STANDBY // standby state
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);

	// select edge, then held selected without hold
	sequence s_select;
		$fell(SPI_CS_N) ##1 (!SPI_CS_N && SPI_HOLD_N) [*6];
	endsequence

	// deselected long enough with no internal cycle
	sequence s_idle;
		(SPI_CS_N && !BUSY) [*8];
	endsequence

	a_select_drive: assert property (s_select |-> SPI_SDO_OE)
		else $error("output not driven after select");
	a_cs_active: assert property (!SPI_CS_N [*6] |-> !STANDBY)
		else $error("standby while selected");
	a_deselect_float: assert property (SPI_CS_N [*5] |-> !SPI_SDO_OE)
		else $error("output driven while deselected");
	a_hold_float: assert property (!SPI_HOLD_N [*5] |-> !SPI_SDO_OE)
		else $error("output driven during hold");
	a_standby_idle: assert property (s_idle |-> STANDBY)
		else $error("no standby when idle");
	a_busy_active: assert property (BUSY [*2] |-> !STANDBY)
		else $error("standby during internal cycle");
	a_busy_min: assert property ($rose(BUSY) |-> BUSY [*8])
		else $error("busy dropped too early");
	a_busy_start: assert property ($rose(BUSY) |-> SPI_CS_N && $past(SPI_CS_N, 2))
		else $error("cycle started while selected");
	a_sdo_on_fall: assert property (SPI_SDO_OE && $past(SPI_SDO_OE) && $changed(SPI_SDO)
		|-> !$past(SPI_CLK, 2))
		else $error("output changed away from clock fall");
endmodule

bind sfsp_front_end sfsp_checker chk
(
	.CLOCK(CLOCK), .RSTN(RSTN), .SPI_CLK(SPI_CLK), .SPI_CS_N(SPI_CS_N), .SPI_SDI(SPI_SDI),
	.SPI_HOLD_N(SPI_HOLD_N), .SPI_WP_N(SPI_WP_N), .SPI_SDO(SPI_SDO), .SPI_SDO_OE(SPI_SDO_OE),
	.BUSY(BUSY), .STANDBY(STANDBY)
);

// File: sim/sfsp_front_end_tb.sv
`timescale 1ns/1ps

`define CHK(g, e) \
	begin \
		samples_checked++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("mismatch at %0t got %h exp %h", $time, (g), (e)); \
		end \
	end

module sfsp_front_end_tb
	import sfsp_pkg::*;
;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic wp_n = 1'b1;
	logic sck, cs_n, sdi, hold_n, sdo, sdo_oe, busy, standby;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	sfsp_front_end #(.SECTORS(4), .PAGES(4), .PAGE_BYTES(16)) dut
	(
		.CLOCK(clock), .RSTN(rstn), .SPI_CLK(sck), .SPI_CS_N(cs_n), .SPI_SDI(sdi),
		.SPI_HOLD_N(hold_n), .SPI_WP_N(wp_n), .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe),
		.BUSY(busy), .STANDBY(standby)
	);

	sfsp_master host
	(
		.clk(clock), .sck(sck), .cs_n(cs_n), .sdi(sdi), .hold_n(hold_n),
		.sdo(sdo_oe ? sdo : 1'bz), .sdo_oe(sdo_oe)
	);

	always #50 clock = ~clock;

	// watchdog on the whole run
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one-byte command frame
	task automatic op(input logic [7:0] c);
		logic [7:0] r;
		host.open_frame();
		host.xfer(c, 8, r);
		host.close_frame();
	endtask

	task automatic status(output logic [7:0] s);
		logic [7:0] r;
		host.open_frame();
		host.xfer(OP_STATUS_READ, 8, r);
		host.xfer(8'h00, 8, s);
		host.close_frame();
	endtask

	// opcode and address, frame left open
	task automatic head(input logic [7:0] c, input logic [23:0] a);
		logic [7:0] r;
		host.open_frame();
		host.xfer(c, 8, r);
		host.xfer(a[23:16], 8, r);
		host.xfer(a[15:8], 8, r);
		host.xfer(a[7:0], 8, r);
	endtask

	// bounded wait for the internal cycle to end
	task automatic settle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000)
		begin
			@(negedge clock);
			n++;
		end
		`CHK(n < 2000, 1'b1)
	endtask

	task automatic pgw(input logic [23:0] a, input logic [15:0] d, input int nb);
		logic [7:0] r;
		op(OP_WRITE_ENABLE);
		head(OP_PAGE_WRITE, a);
		for (int i = 0; i < nb; i++)
			host.xfer(d[15 - 8 * i -: 8], 8, r);
		host.close_frame();
		settle();
	endtask

	// four-byte read, first byte in the top bits of e
	task automatic rd4(input logic [23:0] a, input logic [31:0] e);
		logic [7:0] r;
		head(OP_DATA_READ, a);
		for (int i = 0; i < 4; i++)
		begin
			host.xfer(8'h00, 8, r);
			`CHK(r, e[31 - 8 * i -: 8])
		end
		host.close_frame();
	endtask

	task automatic sw(input logic [7:0] v);
		logic [7:0] r;
		op(OP_WRITE_ENABLE);
		host.open_frame();
		host.xfer(OP_STATUS_WRITE, 8, r);
		host.xfer(v, 8, r);
		host.close_frame();
		settle();
	endtask

	task automatic t_reset();
		`CHK(sdo_oe, 1'b0)
		`CHK(busy, 1'b0)
		`CHK(standby, 1'b1)
	endtask

	// both clock idle levels, mode 3 first
	task automatic t_modes();
		logic [7:0] s;
		for (int m = 1; m >= 0; m--)
		begin
			host.cpol = m[0];
			op(OP_WRITE_ENABLE);
			status(s);
			`CHK(s, 8'h02)
			op(OP_WRITE_DISABLE);
			status(s);
			`CHK(s, 8'h00)
		end
	endtask

	// wipe, write across a sector edge, wipe one sector
	task automatic t_memory();
		logic [7:0] s;
		op(OP_WRITE_ENABLE);
		op(OP_FULL_WIPE);
		`CHK(busy, 1'b1)
		`CHK(standby, 1'b0)
		status(s);
		`CHK(s[0], 1'b1)
		settle();
		pgw(24'h00003f, 16'ha500, 1);
		pgw(24'h000040, 16'h3c5a, 2);
		rd4(24'h00003e, 32'hffa53c5a);
		op(OP_WRITE_ENABLE);
		head(OP_REGION_WIPE, 24'h000040);
		host.close_frame();
		settle();
		rd4(24'h00003e, 32'hffa5ffff);
	endtask

	// a trailing partial byte cancels the write
	task automatic t_partial();
		logic [7:0] r;
		op(OP_WRITE_ENABLE);
		head(OP_PAGE_WRITE, 24'h000041);
		host.xfer(8'h00, 8, r);
		host.xfer(8'h00, 3, r);
		host.close_frame();
		`CHK(busy, 1'b0)
		status(r);
		`CHK(r, 8'h02)
		rd4(24'h00003e, 32'hffa5ffff);
		op(OP_WRITE_DISABLE);
	endtask

	// hold between bytes with noise on clock and data
	task automatic t_hold();
		logic [7:0] r;
		logic oe;
		op(OP_WRITE_ENABLE);
		host.open_frame();
		host.xfer(OP_STATUS_READ, 8, r);
		host.pause(4, oe);
		`CHK(oe, 1'b0)
		host.xfer(8'h00, 8, r);
		host.close_frame();
		`CHK(r, 8'h02)
		op(OP_WRITE_DISABLE);
	endtask

	task automatic t_protect();
		logic [7:0] s;
		sw(8'h84);
		status(s);
		`CHK(s, 8'h84)
		op(OP_WRITE_ENABLE);
		head(OP_REGION_WIPE, 24'h0000c0);
		host.close_frame();
		`CHK(busy, 1'b0)
		status(s);
		`CHK(s, 8'h86)
		wp_n = 1'b0;
		sw(8'h00);
		status(s);
		`CHK(s & 8'hfc, 8'h84)
		wp_n = 1'b1;
		sw(8'h00);
		status(s);
		`CHK(s, 8'h00)
	endtask

	initial
	begin
		repeat (2) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		t_reset();
		t_modes();
		t_memory();
		t_partial();
		t_hold();
		t_protect();
		conclude();
	end
endmodule

// File: sim/sfsp_master.sv
`timescale 1ns/1ps

// serial bus master, 800 ns clock, moves on bench clock falls
module sfsp_master
(
	input wire logic clk, // bench clock
	output logic sck, // serial clock
	output logic cs_n, // chip select
	output logic sdi, // data to device
	output logic hold_n, // hold request
	input wire logic sdo, // data line from device
	input wire logic sdo_oe // device drive enable
);
	// idle level of the serial clock
	logic cpol = 1'b0;

	// idle pins at time zero
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		hold_n = 1'b1;
	end

	// half a serial clock period
	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	task automatic open_frame();
		sck = cpol;
		half();
		cs_n = 1'b0;
		half();
	endtask

	// released line flips so a stale level is never trusted
	task automatic close_frame();
		sck = cpol;
		half();
		cs_n = 1'b1;
		sdi = ~sdi;
		half();
	endtask

	// single input line, top bit first
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			sck = 1'b0;
			sdi = d[i];
			half();
			sck = 1'b1;
			half();
			q[i] = sdo;
		end
	endtask

	// hold only inside a selected frame
	task automatic pause(input int n, output logic oe);
		hold_n = 1'b0;
		half();
		oe = sdo_oe;
		repeat (n)
		begin
			sck = ~sck;
			sdi = ~sdi;
			half();
		end
		hold_n = 1'b1;
		half();
	endtask
endmodule
